// ---- common/gpp_pkg.sv ----
// Purpose: Shared constants and types for the port 8 / port 9 block
// Assumes: Plain register port, byte offsets in the low 16 address bits
// Notes:   Port 8 offsets are taken from the port's register summary
package gpp_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] GPP_ADDR_P8_DIR   = 16'hFFCD;
    localparam logic [15:0] GPP_ADDR_P8_LATCH = 16'hFFCF;
    localparam logic [15:0] GPP_ADDR_P9_DIR   = 16'hFFD0;
    localparam logic [15:0] GPP_ADDR_P9_LATCH = 16'hFFD2;

    // ------------------------------------------------------------------
    // Reset values and fixed fields
    // ------------------------------------------------------------------
    localparam logic [7:0] GPP_P8_DIR_RST   = 8'hE0;
    localparam logic [7:0] GPP_P8_LATCH_RST = 8'hE0;
    localparam logic [7:0] GPP_P9_DIR_RST   = 8'hC0;
    localparam logic [7:0] GPP_P9_LATCH_RST = 8'hC0;
    localparam logic [7:0] GPP_P8_FIXED     = 8'hE0;
    localparam logic [7:0] GPP_P9_FIXED     = 8'hC0;
    localparam logic [7:0] GPP_ALL_ONES     = 8'hFF;
    localparam logic [7:0] GPP_UNMAPPED     = 8'h00;
    localparam int         GPP_P8_PINS      = 2;
    localparam int         GPP_P9_PINS      = 6;

    // ------------------------------------------------------------------
    // Pin carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [GPP_P8_PINS-1:0] level;
        logic [GPP_P8_PINS-1:0] enable;
    } gpp_p8_pad_s;

    typedef struct packed {
        logic [GPP_P9_PINS-1:0] level;
        logic [GPP_P9_PINS-1:0] enable;
    } gpp_p9_pad_s;

    typedef enum logic [1:0] {
        GPP_MODE_RUN    = 2'b00,
        GPP_MODE_SWSTBY = 2'b01,
        GPP_MODE_HWSTBY = 2'b10
    } gpp_power_e;

endpackage

// ---- rtl/gpp_port8_port9.sv ----
// Purpose: Port 8 (2 pins) and port 9 (6 pins) general-purpose I/O
// Assumes: One clock; software strobes are one cycle wide
// Notes:   Serial and interrupt pin multiplexing of port 9 is outside
//
// Function
// (RULE1) Port 8 direction is write-only, bits 1..0 set pin output, 7..5 read 1.
// (RULE2) Port 8 direction resets to E0 by reset or hardware standby only.
// (RULE3) In software standby output pins keep driving their level.
// (RULE4) Port 8 read gives latch where direction is 1, pin level otherwise.
// (RULE5) Port 8 latch bits 7..5 ignore writes and read 1.
// (RULE6) Port 8 latch bits 4..2 are storage, read when direction 1, else 1.
// (RULE7) Port 8 latch resets to E0 by reset or hardware standby only.
// (RULE8) Pin 1 output is legal only in modes 6 and 7; pin 0 always obeys.
// (RULE9) Port 8 pins always feed external interrupts 1 and 0.
// (RULE10) Port 9 is a 6-bit port shared with serial and interrupts 5 and 4.
// (RULE11) A port 9 pin is output when its direction bit is 1.
// (RULE12) Port 9 direction is write-only and reads all ones.
// (RULE13) Port 9 direction resets to C0 by reset or hardware standby only.
// (RULE14) Port 9 direction is 8 bits, 7..6 fixed 1, 5..0 one per pin.
// (RULE15) Port 9 read gives latch where direction 1, else pin; 7..6 read 1.
// (RULE16) Input pin levels pass a two-stage synchroniser before reading.
`timescale 1ns/1ps

module gpp_port8_port9 #(
    parameter int P8_PINS = gpp_pkg::GPP_P8_PINS,
    parameter int P9_PINS = gpp_pkg::GPP_P9_PINS
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 hwStandby,
    input  wire logic                 swStandby,
    input  wire logic                 singleChipMode,
    input  wire logic [15:0]          regAddr,
    input  wire logic [7:0]           regWdata,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic      [7:0]           regRdata,
    input  wire logic [P8_PINS-1:0]   port8PinIn,
    output gpp_pkg::gpp_p8_pad_s      port8Pad,
    input  wire logic [P9_PINS-1:0]   port9PinIn,
    output gpp_pkg::gpp_p9_pad_s      port9Pad,
    output logic                      external_interrupt_0,
    output logic                      external_interrupt_1,
    output logic      [P9_PINS-1:0]   port9PeriphIn,
    output gpp_pkg::gpp_power_e       powerState
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]         port8_direction;
    logic [7:0]         port8_output_latch;
    logic [7:0]         port9_direction;
    logic [7:0]         port9_output_latch;
    logic [P8_PINS-1:0] p8Meta;
    logic [P8_PINS-1:0] p8Sync;
    logic [P9_PINS-1:0] p9Meta;
    logic [P9_PINS-1:0] p9Sync;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic       selP8Dir   = regAddr == gpp_pkg::GPP_ADDR_P8_DIR;
    wire logic       selP8Latch = regAddr == gpp_pkg::GPP_ADDR_P8_LATCH;
    wire logic       selP9Dir   = regAddr == gpp_pkg::GPP_ADDR_P9_DIR;
    wire logic       selP9Latch = regAddr == gpp_pkg::GPP_ADDR_P9_LATCH;
    // Hardware standby holds the four port registers at reset values; software standby is
    // transparent to the registers so writes during it still land.
    wire logic       wrP8Dir    = regWrite & selP8Dir;
    wire logic       wrP8Latch  = regWrite & selP8Latch;
    wire logic       wrP9Dir    = regWrite & selP9Dir;
    wire logic       wrP9Latch  = regWrite & selP9Latch;

    // Reserved high bits forced to one on every write
    wire logic [7:0] next_p8Dir   = regWdata | gpp_pkg::GPP_P8_FIXED; // RULE1
    wire logic [7:0] next_p8Latch = regWdata | gpp_pkg::GPP_P8_FIXED; // RULE5
    wire logic [7:0] next_p9Dir   = regWdata | gpp_pkg::GPP_P9_FIXED; // RULE14
    wire logic [7:0] next_p9Latch = regWdata | gpp_pkg::GPP_P9_FIXED; // RULE15

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            port8_direction    <= gpp_pkg::GPP_P8_DIR_RST;   // RULE2
            port8_output_latch <= gpp_pkg::GPP_P8_LATCH_RST; // RULE7
            port9_direction    <= gpp_pkg::GPP_P9_DIR_RST;   // RULE13
            port9_output_latch <= gpp_pkg::GPP_P9_LATCH_RST;
        end else if (hwStandby) begin
            port8_direction    <= gpp_pkg::GPP_P8_DIR_RST;   // RULE2
            port8_output_latch <= gpp_pkg::GPP_P8_LATCH_RST; // RULE7
            port9_direction    <= gpp_pkg::GPP_P9_DIR_RST;   // RULE13
            port9_output_latch <= gpp_pkg::GPP_P9_LATCH_RST;
        end else begin
            if (wrP8Dir) begin
                port8_direction <= next_p8Dir;
            end
            if (wrP8Latch) begin
                port8_output_latch <= next_p8Latch;
            end
            if (wrP9Dir) begin
                port9_direction <= next_p9Dir;
            end
            if (wrP9Latch) begin
                port9_output_latch <= next_p9Latch;
            end
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            p8Meta <= '0;
            p8Sync <= '0;
            p9Meta <= '0;
            p9Sync <= '0;
        end else begin
            p8Meta <= port8PinIn; // RULE16
            p8Sync <= p8Meta;     // RULE16
            p9Meta <= port9PinIn; // RULE16
            p9Sync <= p9Meta;     // RULE16
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Pin 1 output refused in expanded modes, so a bad setting cannot
    // fight the board; pin 0 obeys its bit in every mode.
    wire logic [P8_PINS-1:0] p8Drive = {
        port8_direction[1] & singleChipMode,                    // RULE8
        port8_direction[0]};                                    // RULE8

    // Drive stays on in software standby: no standby gating here
    assign port8Pad.enable = p8Drive;                           // RULE3
    assign port8Pad.level  = port8_output_latch[P8_PINS-1:0];
    assign port9Pad.enable = port9_direction[P9_PINS-1:0];      // RULE11
    assign port9Pad.level  = port9_output_latch[P9_PINS-1:0];   // RULE3

    // Interrupt inputs watch the pin whatever the direction
    assign external_interrupt_0 = p8Sync[0];                    // RULE9
    assign external_interrupt_1 = p8Sync[1];                    // RULE9
    assign port9PeriphIn        = p9Sync;                       // RULE10

    assign powerState = hwStandby ? gpp_pkg::GPP_MODE_HWSTBY :
                        swStandby ? gpp_pkg::GPP_MODE_SWSTBY :
                                    gpp_pkg::GPP_MODE_RUN;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    function automatic logic [7:0] mixRead(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pins);
        mixRead = (dir & latch) | (~dir & pins);
    endfunction

    // Storage bits 4..2 have no pin; they read as one when not selected
    wire logic [7:0] p8PinView = {3'h7, 3'h7, p8Sync};         // RULE6
    wire logic [7:0] p9PinView = {2'h3, p9Sync};
    wire logic [7:0] p8ReadVal = mixRead(port8_direction,
                                         port8_output_latch,
                                         p8PinView);            // RULE4
    wire logic [7:0] p9ReadVal = mixRead(port9_direction,
                                         port9_output_latch,
                                         p9PinView);            // RULE15

    wire logic [7:0] readMux =
        selP8Dir   ? gpp_pkg::GPP_ALL_ONES :                    // RULE1
        selP8Latch ? p8ReadVal :
        selP9Dir   ? gpp_pkg::GPP_ALL_ONES :                    // RULE12
        selP9Latch ? p9ReadVal :
                     gpp_pkg::GPP_UNMAPPED;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= '0;
        end else if (regRead) begin
            regRdata <= readMux;
        end else begin
            regRdata <= '0;
        end
    end

endmodule // gpp_port8_port9

// ---- dv/gpp_board_model.sv ----
// Purpose: Board logic on the port 8 / port 9 pins
// Assumes: Push-pull pads; the board level shows where undriven
// Notes:   No pull resistors on the board
`timescale 1ns/1ps
module gpp_board_model (
    input  wire gpp_pkg::gpp_p8_pad_s p8Pad,
    input  wire gpp_pkg::gpp_p9_pad_s p9Pad,
    input  wire logic [1:0]           p8Board,
    input  wire logic [5:0]           p9Board,
    output logic      [1:0]           p8Pin,
    output logic      [5:0]           p9Pin
);
    // Driven pins win, so a stuck enable shows in reads
    assign p8Pin = (p8Pad.enable & p8Pad.level)
                 | (~p8Pad.enable & p8Board);
    assign p9Pin = (p9Pad.enable & p9Pad.level)
                 | (~p9Pad.enable & p9Board);
endmodule // gpp_board_model

// ---- dv/gpp_port8_port9_monitor.sv ----
// Purpose: Port-level checks of the port 8 / port 9 block
// Assumes: Bound to the top module, one clock domain
// Notes:   Pin reads lag two cycles behind the pins
`timescale 1ns/1ps
module gpp_port8_port9_monitor #(
    parameter int P8_PINS = 2,
    parameter int P9_PINS = 6
) (
    input wire logic               sys_clk,
    input wire logic               rst_b,
    input wire logic               hwStandby,
    input wire logic               swStandby,
    input wire logic               singleChipMode,
    input wire logic [15:0]        regAddr,
    input wire logic [7:0]         regWdata,
    input wire logic               regWrite,
    input wire logic               regRead,
    input wire logic [7:0]         regRdata,
    input wire logic [P8_PINS-1:0] port8PinIn,
    input wire gpp_pkg::gpp_p8_pad_s port8Pad,
    input wire logic [P9_PINS-1:0] port9PinIn,
    input wire gpp_pkg::gpp_p9_pad_s port9Pad,
    input wire logic               external_interrupt_0,
    input wire logic               external_interrupt_1,
    input wire logic [P9_PINS-1:0] port9PeriphIn
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr(logic [15:0] a); regWrite && !hwStandby && regAddr == a;
    endsequence
    sequence s_rd(logic [15:0] a); regRead && regAddr == a; endsequence
    a_p9_dir_drive: assert property (s_wr(16'hFFD0) |=>
        port9Pad.enable == $past(regWdata[5:0])) else $error("p9 enable");
    a_p9_lvl_drive: assert property (s_wr(16'hFFD2) |=>
        port9Pad.level == $past(regWdata[5:0])) else $error("p9 level");
    a_p9_dir_ones: assert property (s_rd(16'hFFD0) |=>
        regRdata == 8'hFF) else $error("p9 dir read");
    a_p8_rsvd_ones: assert property (s_rd(16'hFFCF) |=>
        regRdata[7:5] == 3'b111) else $error("p8 reserved");
    a_hw_clear: assert property (hwStandby |=>
        port9Pad.enable == '0 && port8Pad.enable == '0) else $error("hw");
    a_sw_hold: assert property (swStandby && !hwStandby && !regWrite |=>
        $stable(port9Pad)) else $error("sw hold");
    a_irq_sync: assert property ($past(rst_b, 2) |->
        {external_interrupt_1, external_interrupt_0} == $past(port8PinIn, 2))
        else $error("irq path");
    a_periph_sync: assert property ($past(rst_b, 2) |->
        port9PeriphIn == $past(port9PinIn, 2)) else $error("p9 periph");
    a_p8_pin_gate: assert property (!singleChipMode |->
        !port8Pad.enable[1]) else $error("p8 pin1 driven");
endmodule // gpp_port8_port9_monitor
bind gpp_port8_port9 gpp_port8_port9_monitor
    #(.P8_PINS(P8_PINS), .P9_PINS(P9_PINS)) uMon (.*);

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the port 8 / port 9 block
// Assumes: Board shows 2A on port 9 and 01 on port 8 (10 in the reset case) where undriven
// Notes:   Table rows first, then standby and reset cases
`timescale 1ns/1ps
module tb;
    logic sys_clk, rst_b, hwStandby, swStandby, singleChipMode;
    logic regWrite, regRead, external_interrupt_0, external_interrupt_1;
    logic [15:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [1:0] port8PinIn, p8Board;
    logic [5:0] port9PinIn, p9Board, port9PeriphIn;
    gpp_pkg::gpp_p8_pad_s port8Pad;
    gpp_pkg::gpp_p9_pad_s port9Pad;
    gpp_pkg::gpp_power_e powerState;
    int errorCnt, nTests;
    typedef struct { logic [15:0] a; logic [7:0] d; logic [15:0] r;
                     logic [7:0] e; } gpp_row_s;
    gpp_row_s rows [6] = '{'{16'hFFD0, 8'h0F, 16'hFFD0, 8'hFF},
        '{16'hFFD2, 8'h35, 16'hFFD2, 8'hE5}, '{16'hFFCD, 8'h1D, 16'hFFCD, 8'hFF},
        '{16'hFFCF, 8'h1E, 16'hFFCF, 8'hFC}, '{16'hFFCD, 8'h03, 16'hFFCF, 8'hFE},
        '{16'hFFCE, 8'h55, 16'hFFCE, 8'h00}};
    gpp_port8_port9 dut (.*);
    gpp_board_model board (.p8Pad(port8Pad), .p9Pad(port9Pad),
        .p8Board(p8Board), .p9Board(p9Board), .p8Pin(port8PinIn),
        .p9Pin(port9PinIn));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(negedge sys_clk);
        chk({4'h0, regRdata}, {4'h0, e});
        @(posedge sys_clk);
    endtask
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #50000;
        errorCnt++;
        wrapUp();
    end
    initial begin
        {rst_b, hwStandby, swStandby, regWrite, regRead} = 5'h00;
        singleChipMode = 1'b1;
        regAddr = 16'h0000;
        regWdata = 8'h00;
        p8Board = 2'h1;
        p9Board = 6'h2A;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].r, rows[i].e);
            $display("row %0d done", i);
        end
        wr(16'hFFD0, 8'h3F);
        rd(16'hFFD2, 8'hF5);
        swStandby <= 1'b1;
        singleChipMode <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(port9Pad, {6'h35, 6'h3F});
        chk({10'h0, port8Pad.enable}, 12'h001);
        chk({10'h0, port8Pad.level}, 12'h002);
        chk({10'h0, powerState}, 12'h001);
        @(posedge sys_clk);
        hwStandby <= 1'b1;
        wr(16'hFFD2, 8'h3F);
        {hwStandby, swStandby, singleChipMode} <= 3'b001;
        repeat (3) @(posedge sys_clk);
        rd(16'hFFD2, 8'hEA);
        rd(16'hFFCF, 8'hFD);
        $display("standby test done");
        p8Board <= 2'h2;
        wr(16'hFFD2, 8'h15);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(16'hFFD2, 8'hEA);
        rd(16'hFFCF, 8'hFE);
        chk({10'h0, powerState}, 12'h000);
        $display("reset test done");
        wrapUp();
    end
endmodule // tb
